/* File: logic/dsfl_consts.svh */
// named constants for the low status word flag logic
`ifndef DSFL_CONSTS_SVH
`define DSFL_CONSTS_SVH
`define DSFL_BIT_IN1        0
`define DSFL_BIT_IN2        1
`define DSFL_BIT_TEMP90     4
`define DSFL_BIT_CONN_LOST  6
`define DSFL_BIT_DRV_FAULT  7
`define DSFL_BIT_INV_JOG    9
`define DSFL_BIT_LIMIT      10
`define DSFL_WORD_W         16
`define DSFL_TEMP_W         8
`define DSFL_WARN_DEG       8'd90
`define DSFL_FAULT_DEG      8'd95
`define DSFL_ZERO_WORD      16'h0000
`define DSFL_LOW_MASK       16'h06d3
`define DSFL_SYNC_W         5
`define DSFL_SYNC_RST       5'h10
`define DSFL_SYN_CW         0
`define DSFL_SYN_CCW        1
`define DSFL_SYN_IN1        2
`define DSFL_SYN_IN2        3
`define DSFL_SYN_LINK       4
`define DSFL_IN_CH          2
`endif

/* File: logic/dsfl_pkg.sv */
// types for the low status word flag logic
package dsfl_pkg;
  // selects which jog parameter the host is changing
  typedef enum logic [2:0] {
    DSFL_PAR_SPEED = 3'h1,
    DSFL_PAR_ACCEL = 3'h2,
    DSFL_PAR_DECEL = 3'h4
  } dsfl_par_type;
endpackage

/* File: logic/dsfl_status_low.sv */
// status flag logic for the low eleven bits of the second status word
// Contract
// R1: limit flag set on switch during move
// R2: limit clears on switch release or reset
// R3: invalid jog value sets bit 9
// R4: only speed, accel, decel change in jog
// R5: reserved bits 8,5,3,2 read zero
// R6: driver fault bit follows overtemp when enabled
// R7: fault withholds current, self-clears when cool
// R8: connection-lost set when physical link returns
// R9: connection-lost also sets input error
// R10: protocol loss alone leaves flag alone
// R11: temp warning above 90 degrees C
// R12: bit 1 is input 2 active
// R13: bit 0 is input 1 active
// R14: above 95 degrees remove current, report
// R15: host error reset clears latched flags
// R16: flags registered as one coherent word
// R17: pins synchronised before use
`include "dsfl_consts.svh"
module dsfl_status_low (
  input  wire logic                    clk_sys_i,       // system clock
  input  wire logic                    nrst_i,          // async reset, low
  input  wire logic                    limit_cw_i,      // end switch pin, active high
  input  wire logic                    limit_ccw_i,     // end switch pin, active high
  input  wire logic                    in1_pin_i,       // discrete input 1 pin
  input  wire logic                    in2_pin_i,       // discrete input 2 pin
  input  wire logic                    in1_pol_i,       // 1: input 1 active high
  input  wire logic                    in2_pol_i,       // 1: input 2 active high
  input  wire logic                    moving_i,        // a move is in progress
  input  wire logic                    jog_active_i,    // a jog move is running
  input  wire logic                    jog_wr_i,        // host writes a jog parameter
  input  wire dsfl_pkg::dsfl_par_type  jog_par_i,       // which parameter
  input  wire logic                    jog_val_ok_i,    // value within range
  input  wire logic                    reset_errors_i,  // host error reset pulse
  input  wire logic                    drv_enable_i,    // driver section enabled
  input  wire logic [`DSFL_TEMP_W-1:0] motor_temp_i,    // thermistor, degrees C
  input  wire logic [`DSFL_TEMP_W-1:0] cpu_temp_i,      // processor temp, degrees C
  input  wire logic                    phy_link_i,      // physical link up pin
  output logic [`DSFL_WORD_W-1:0]      status_word_o,   // low part of status word
  output logic                         input_err_set_o, // pulse: set input error
  output logic                         jog_accept_o,    // pulse: parameter taken
  output logic                         motor_cur_en_o   // motor current allowed
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [`DSFL_SYNC_W-1:0] sync1_r;   // first stage, read only by second
  logic [`DSFL_SYNC_W-1:0] sync2_r;   // second stage, safe to use
  logic [`DSFL_SYNC_W-1:0] pins;      // raw pins gathered

  // pin order matches the index names in the constants header
  assign pins = {phy_link_i, in2_pin_i, in1_pin_i, limit_ccw_i, limit_cw_i};

  // two-flop synchroniser per pin
  // link stages reset as up: a link already up at release must not
  // look like a return and raise the connection-lost flag
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_r <= `DSFL_SYNC_RST; // switches and inputs idle, link up
      sync2_r <= `DSFL_SYNC_RST;
    end else begin
      sync1_r <= pins; // R17
      sync2_r <= sync1_r; // R17
    end
  end

  // synchronised levels, named by use
  logic lim_s;    // any end switch active
  logic in1_s;    // input 1 level
  logic in2_s;    // input 2 level
  logic link_s;   // physical link level
  // both end switches share one limit flag
  assign lim_s  = sync2_r[`DSFL_SYN_CW] | sync2_r[`DSFL_SYN_CCW];
  assign in1_s  = sync2_r[`DSFL_SYN_IN1];
  assign in2_s  = sync2_r[`DSFL_SYN_IN2];
  assign link_s = sync2_r[`DSFL_SYN_LINK];

  // ************************************************************
  // discrete input flags, one per channel
  // ************************************************************
  logic [`DSFL_IN_CH-1:0] in_lvl; // synchronised input levels
  logic [`DSFL_IN_CH-1:0] in_pol; // configured active levels
  logic [`DSFL_IN_CH-1:0] in_on;  // input in its active state
  assign in_lvl = {in2_s, in1_s};
  assign in_pol = {in2_pol_i, in1_pol_i};
  // active when the level matches the configured polarity
  for (genvar ch = 0; ch < `DSFL_IN_CH; ch++) begin : g_in_flag
    assign in_on[ch] = ~(in_lvl[ch] ^ in_pol[ch]); // R12 R13
  end

  // ************************************************************
  // flag state
  // ************************************************************
  // previous levels for the edge detectors
  logic lim_q_r,  lim_q_nxt;    // previous switch level
  logic link_q_r, link_q_nxt;   // previous link level
  // latched flags, held until released or cleared
  logic limit_r,  limit_nxt;    // limit flag
  logic injog_r,  injog_nxt;    // invalid jog change flag
  logic conn_r,   conn_nxt;     // connection-lost flag
  // one-cycle pulses toward the rest of the device
  logic inerr_r,  inerr_nxt;    // input error set pulse
  logic acc_r,    acc_nxt;      // jog accept pulse
  // the word the host reads, built and registered as one
  logic [`DSFL_WORD_W-1:0] word_r, word_nxt; // coherent snapshot
  // live conditions decoded every cycle
  logic fault_now;              // overtemp fault condition
  logic warn_now;               // processor temp warning
  logic par_ok;                 // permitted jog parameter

  // thermal conditions
  assign fault_now = motor_temp_i > `DSFL_FAULT_DEG; // R14
  assign warn_now  = cpu_temp_i > `DSFL_WARN_DEG; // R11
  // only three parameters may change in flight
  assign par_ok = (jog_par_i == dsfl_pkg::DSFL_PAR_SPEED) ||
                  (jog_par_i == dsfl_pkg::DSFL_PAR_ACCEL) ||
                  (jog_par_i == dsfl_pkg::DSFL_PAR_DECEL); // R4

  // next state for all flags
  always_comb begin
    // edge detectors remember the last synchronised level
    lim_q_nxt  = lim_s;
    link_q_nxt = link_s;
    // limit: set beats clear
    limit_nxt = limit_r;
    if (reset_errors_i || (lim_q_r && !lim_s)) begin
      // host clear, or switch went from active to inactive
      limit_nxt = 1'b0; // R2 R15
    end
    if (lim_s && moving_i) begin
      // end of travel reached while moving
      limit_nxt = 1'b1; // R1
    end
    // invalid jog: cleared by error reset, set wins
    injog_nxt = injog_r;
    acc_nxt   = 1'b0;
    if (reset_errors_i) begin
      injog_nxt = 1'b0; // R15
    end
    // writes outside a jog, or to other parameters, are ignored
    if (jog_active_i && jog_wr_i && par_ok) begin
      if (jog_val_ok_i) begin
        // in-range value taken, one-cycle acknowledge
        acc_nxt = 1'b1; // R4
      end else begin
        // out-of-range value: flag it, keep the old setting
        injog_nxt = 1'b1; // R3
      end
    end
    // connection lost: set on physical link return only
    conn_nxt  = conn_r;
    inerr_nxt = 1'b0;
    if (reset_errors_i) begin
      conn_nxt = 1'b0; // R15
    end
    // only the physical link is watched, so a protocol-level
    // loss with the link still up never reaches this flag
    if (link_s && !link_q_r) begin
      conn_nxt  = 1'b1; // R8 R10
      inerr_nxt = 1'b1; // R9
    end
    // assemble word, reserved bits stay zero
    word_nxt = `DSFL_ZERO_WORD; // R5
    // latched flags follow their next value, so the word and the
    // flag registers never disagree
    word_nxt[`DSFL_BIT_LIMIT]     = limit_nxt;
    word_nxt[`DSFL_BIT_INV_JOG]   = injog_nxt;
    // live conditions follow their inputs one cycle later; connection-lost follows its next value
    word_nxt[`DSFL_BIT_DRV_FAULT] = drv_enable_i & fault_now; // R6
    word_nxt[`DSFL_BIT_CONN_LOST] = conn_nxt;
    word_nxt[`DSFL_BIT_TEMP90]    = warn_now; // R11
    word_nxt[`DSFL_BIT_IN2]       = in_on[1]; // R12
    word_nxt[`DSFL_BIT_IN1]       = in_on[0]; // R13
  end

  // registers only
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // flags clear, link history up
      lim_q_r  <= 1'b0;
      link_q_r <= 1'b1;
      limit_r  <= 1'b0;
      injog_r  <= 1'b0;
      conn_r   <= 1'b0;
      inerr_r  <= 1'b0;
      acc_r    <= 1'b0;
      word_r   <= `DSFL_ZERO_WORD;
    end else begin
      // the word moves with its flags on the same edge
      lim_q_r  <= lim_q_nxt;
      link_q_r <= link_q_nxt;
      limit_r  <= limit_nxt;
      injog_r  <= injog_nxt;
      conn_r   <= conn_nxt;
      inerr_r  <= inerr_nxt;
      acc_r    <= acc_nxt;
      word_r   <= word_nxt; // R16
    end
  end

  // current withheld while fault persists, returns by itself
  // no latch here: current comes back once the thermistor reads safe
  logic cur_r, cur_nxt; // motor current enable
  always_comb begin
    cur_nxt = drv_enable_i & ~fault_now; // R7 R14
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_r <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // every output comes straight from a flip-flop
  assign status_word_o   = word_r;
  assign input_err_set_o = inerr_r;
  assign jog_accept_o    = acc_r;
  assign motor_cur_en_o  = cur_r;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // switch seen active, then released
  sequence s_switch_release;
    lim_s ##1 !lim_s;
  endsequence

  // physical link seen down, then up again
  sequence s_link_return;
    !link_s ##1 link_s;
  endsequence

  // physical link up on two samples running, no edge to report
  sequence s_link_steady;
    link_s ##1 link_s;
  endsequence

  // reserved positions read zero
  a_reserved_zero: assert property ((status_word_o & ~`DSFL_LOW_MASK) == `DSFL_ZERO_WORD) // R5
    else $error("reserved status bits not zero");

  // limit flag: set, hold, clear
  a_limit_set: assert property (lim_s && moving_i |=> status_word_o[`DSFL_BIT_LIMIT]) // R1
    else $error("limit flag not set");
  a_limit_hold: assert property (status_word_o[`DSFL_BIT_LIMIT] && lim_s && !reset_errors_i // R1
                                 |=> status_word_o[`DSFL_BIT_LIMIT])
    else $error("limit flag dropped while switch active");
  a_limit_clr: assert property (s_switch_release |=> !status_word_o[`DSFL_BIT_LIMIT]) // R2
    else $error("limit flag not cleared on release");
  a_limit_reset: assert property (reset_errors_i && !(lim_s && moving_i) // R2
                                  |=> !status_word_o[`DSFL_BIT_LIMIT])
    else $error("limit flag not cleared by error reset");

  // jog parameter changes
  a_jog_bad: assert property (jog_active_i && jog_wr_i && par_ok && !jog_val_ok_i // R3
                              |=> status_word_o[`DSFL_BIT_INV_JOG])
    else $error("invalid jog flag not set");
  a_jog_clear: assert property (reset_errors_i && !jog_wr_i // R15
                                |=> !status_word_o[`DSFL_BIT_INV_JOG])
    else $error("invalid jog flag not cleared by error reset");
  a_jog_take: assert property (jog_active_i && jog_wr_i && par_ok && jog_val_ok_i // R4
                               |=> jog_accept_o)
    else $error("legal jog change not accepted");
  a_jog_par: assert property (!par_ok |=> !jog_accept_o) // R4
    else $error("forbidden jog parameter accepted");
  a_jog_idle: assert property (!jog_active_i |=> !jog_accept_o) // R4
    else $error("jog change accepted outside a jog");

  // thermal flags and motor current
  a_fault_bit: assert property (drv_enable_i && fault_now // R6
                                |=> status_word_o[`DSFL_BIT_DRV_FAULT])
    else $error("driver fault bit missing");
  a_fault_gone: assert property (!fault_now |=> !status_word_o[`DSFL_BIT_DRV_FAULT]) // R6
    else $error("driver fault bit stuck after cooling");
  a_fault_current: assert property (fault_now |=> !motor_cur_en_o) // R7 R14
    else $error("current present during fault");
  a_cur_back: assert property (drv_enable_i && !fault_now |=> motor_cur_en_o) // R7
    else $error("current not restored after cooling");
  a_warn_bit: assert property (warn_now |=> status_word_o[`DSFL_BIT_TEMP90]) // R11
    else $error("temperature warning missing");
  a_warn_off: assert property (!warn_now |=> !status_word_o[`DSFL_BIT_TEMP90]) // R11
    else $error("temperature warning stuck");

  // connection-lost flag and input error pulse
  a_link_flag: assert property (s_link_return |=> status_word_o[`DSFL_BIT_CONN_LOST] // R8
                                && input_err_set_o)
    else $error("link return not flagged");
  a_conn_hold: assert property (s_link_steady ##0 !reset_errors_i // R10
                                |=> $stable(status_word_o[`DSFL_BIT_CONN_LOST]))
    else $error("connection-lost flag moved without a link return");
  a_err_pulse: assert property (input_err_set_o |-> status_word_o[`DSFL_BIT_CONN_LOST]) // R9
    else $error("input error pulse without connection-lost flag");
  a_err_single: assert property (input_err_set_o |=> !input_err_set_o) // R9
    else $error("input error pulse longer than one cycle");

  // discrete input flags track level and polarity
  a_in1_bit: assert property ($past(nrst_i) |-> // R13
      status_word_o[`DSFL_BIT_IN1] == ~($past(in1_s) ^ $past(in1_pol_i)))
    else $error("input 1 flag wrong");
  a_in2_bit: assert property ($past(nrst_i) |-> // R12
      status_word_o[`DSFL_BIT_IN2] == ~($past(in2_s) ^ $past(in2_pol_i)))
    else $error("input 2 flag wrong");

endmodule

/* File: sim/dsfl_host_model.sv */
// host controller model: cyclic reader of the status word
module dsfl_host_model (
  input  wire logic        clk_sys_i,   // system clock
  input  wire logic        nrst_i,      // async reset, low
  input  wire logic [15:0] status_i,    // word from the device
  input  wire logic        clr_req_i,   // bench asks for error reset
  output logic             reset_err_o, // one-cycle error reset command
  output logic [15:0]      snap_o       // last word the host read
);
  timeunit 1ns;
  timeprecision 1ps;
  // one whole-word read per cycle, command one cycle after request
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reset_err_o <= 1'b0;
      snap_o      <= 16'h0000;
    end else begin
      reset_err_o <= clr_req_i;
      snap_o      <= status_i;
    end
  end
endmodule

/* File: sim/tb_drive_status_flags_low.sv */
// self-checking bench for the low status word flags
module tb_drive_status_flags_low;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, lcw = 1'b0, lccw = 1'b0, p1 = 1'b0, p2 = 1'b0;
  logic pol1 = 1'b1, pol2 = 1'b1, mv = 1'b0, jg = 1'b0, jw = 1'b0, jok = 1'b1, clr = 1'b0;
  logic den = 1'b0, phy = 1'b1, ies, jacc, cen, rerr, seen;
  logic [7:0]             mt = 8'h19, ct = 8'h19;   // temperatures, degrees
  logic [15:0]            sw, snap;                 // live word, host copy
  dsfl_pkg::dsfl_par_type jpar = dsfl_pkg::DSFL_PAR_SPEED;
  dsfl_pkg::dsfl_par_type ps[3] = '{dsfl_pkg::DSFL_PAR_SPEED, dsfl_pkg::DSFL_PAR_ACCEL,
                                     dsfl_pkg::DSFL_PAR_DECEL};
  int fail_count = 0, compares = 0, cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  dsfl_status_low u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .limit_cw_i(lcw),
    .limit_ccw_i(lccw), .in1_pin_i(p1), .in2_pin_i(p2), .in1_pol_i(pol1), .in2_pol_i(pol2),
    .moving_i(mv), .jog_active_i(jg), .jog_wr_i(jw), .jog_par_i(jpar), .jog_val_ok_i(jok),
    .reset_errors_i(rerr), .drv_enable_i(den), .motor_temp_i(mt), .cpu_temp_i(ct),
    .phy_link_i(phy), .status_word_o(sw), .input_err_set_o(ies), .jog_accept_o(jacc),
    .motor_cur_en_o(cen));
  dsfl_host_model u_host (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .status_i(sw),
    .clr_req_i(clr), .reset_err_o(rerr), .snap_o(snap));
  // ****************************************
  // helpers and scenarios
  // ****************************************
  task automatic final_report;
    $display("checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait n edges, then let their updates land
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // host error reset through the host model
  task automatic host_clear;
    @(posedge clk_sys_i) clr <= 1'b1;
    @(posedge clk_sys_i) clr <= 1'b0;
    wt(3);
  endtask
  // every pin and polarity pairing, reserved bits stay low
  task automatic t_inputs;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys_i) {p1, p2, pol1, pol2} <= 4'(i);
      wt(4);
      chk(sw & 16'h012f, {14'h0, (p2 == pol2), (p1 == pol1)});
    end
    $display("test inputs done");
  endtask
  // limit set during move, cleared by release and by host reset
  task automatic t_limit;
    @(posedge clk_sys_i) {mv, lcw} <= 2'b11;
    wt(4);
    chk(sw & 16'h0400, 16'h0400);
    @(posedge clk_sys_i) lcw <= 1'b0;
    wt(4);
    chk(sw & 16'h0400, 16'h0000);
    @(posedge clk_sys_i) lccw <= 1'b1;
    wt(4);
    chk(sw & 16'h0400, 16'h0400);
    @(posedge clk_sys_i) mv <= 1'b0;
    host_clear();
    chk(sw & 16'h0400, 16'h0000);
    @(posedge clk_sys_i) lccw <= 1'b0;
    $display("test limit done");
  endtask
  // jog changes: bad value, each legal parameter, forbidden code
  task automatic t_jog;
    @(posedge clk_sys_i) {jg, jw, jok} <= 3'b110;
    @(posedge clk_sys_i) jw <= 1'b0;
    #1 chk(sw & 16'h0200, 16'h0200);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_i) jw <= 1'b1;
      jok  <= 1'b1;
      jpar <= ps[i];
      @(posedge clk_sys_i) jw <= 1'b0;
      #1 chk({15'h0, jacc}, 16'h0001);
    end
    @(posedge clk_sys_i) jw <= 1'b1;
    jpar <= dsfl_pkg::dsfl_par_type'(3'h3);
    @(posedge clk_sys_i) jw <= 1'b0;
    #1 chk({15'h0, jacc}, 16'h0000);
    host_clear();
    chk(sw & 16'h0200, 16'h0000);
    @(posedge clk_sys_i) {jg, jw, jok} <= 3'b010;
    jpar <= dsfl_pkg::DSFL_PAR_SPEED;
    @(posedge clk_sys_i) jw <= 1'b0;
    wt(1);
    chk(sw & 16'h0200, 16'h0000);
    $display("test jog done");
  endtask
  // thermal thresholds on both sides, enable gating
  task automatic t_therm;
    @(posedge clk_sys_i) {den, mt, ct} <= {1'b1, 8'h60, 8'h5b};
    wt(2);
    chk(sw & 16'h0090, 16'h0090);
    chk({15'h0, cen}, 16'h0000);
    @(posedge clk_sys_i) {mt, ct} <= {8'h5f, 8'h5a};
    wt(2);
    chk(sw & 16'h0090, 16'h0000);
    chk({15'h0, cen}, 16'h0001);
    @(posedge clk_sys_i) {den, mt} <= {1'b0, 8'h60};
    wt(2);
    chk(sw & 16'h0080, 16'h0000);
    chk(snap, sw);
    $display("test thermal done");
  endtask
  // link drop and return sets flag and input error pulse
  task automatic t_link;
    seen = 1'b0;
    @(posedge clk_sys_i) phy <= 1'b0;
    wt(5);
    chk(sw & 16'h0040, 16'h0000);
    @(posedge clk_sys_i) phy <= 1'b1;
    repeat (6) begin
      wt(1);
      if (ies === 1'b1) seen = 1'b1;
    end
    chk(sw & 16'h0040, 16'h0040);
    chk({15'h0, seen}, 16'h0001);
    host_clear();
    chk(sw & 16'h0040, 16'h0000);
    $display("test link done");
  endtask
  // cycle ceiling against hangs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      final_report();
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    wt(3);
    t_inputs();
    t_limit();
    t_jog();
    t_therm();
    t_link();
    final_report();
  end
endmodule
